// file: shared/ext_irq_map.svh
// Register offsets, field positions, reset values and vectors of the unit
`ifndef EXT_IRQ_MAP_SVH
`define EXT_IRQ_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets on the special-function bus
// ----------------------------------------------------------------------
`define FLAG_REG_ADDR      8'h91
`define CONTROL_REG_ADDR   8'hd8
`define ENABLE_REG_ADDR    8'he8
`define PRIORITY_REG_ADDR  8'hf8

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define FLAG_FIRST_BIT     4
`define WAKE_FLAG_BIT      3
`define WAKE_SEL_BIT       4

// ----------------------------------------------------------------------
// Fixed read values of reserved bits
// ----------------------------------------------------------------------
`define FLAG_FIXED_BITS    8'h08
`define CONTROL_FIXED_BITS 8'h40
`define SELECT_FIXED_BITS  8'he0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define FLAGS_RESET        5'h00
`define SELECT_RESET       5'h00
`define PC_RESET           16'h0000

// ----------------------------------------------------------------------
// Service routine addresses, by natural order
// ----------------------------------------------------------------------
`define VEC_CONVERSION     16'h0043
`define VEC_SERIAL         16'h004b
`define VEC_RADIO_A        16'h0053
`define VEC_RADIO_B        16'h005b
`define VEC_WAKEUP         16'h0063

`endif

// file: shared/ext_irq_pkg.sv
// Types shared by the extended interrupt unit
package ext_irq_pkg;

  // Source index doubles as natural order, lower wins
  typedef enum logic [2:0] {
    src_conversion,
    src_serial,
    src_radio_a,
    src_radio_b,
    src_wakeup
  } source_type;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } sfr_req_type;

  typedef struct packed {
    logic       take;
    logic       high;
    logic [15:0] vector;
  } take_info_type;

  typedef enum {
    gate_open,
    gate_hold
  } gate_state_type;

endpackage

// file: hw/edge_catcher.sv
// Synchroniser with agreement filter and rising-edge pulse for one event line
`timescale 1ns/1ps
module edge_catcher (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic nrst,
  // Asynchronous event line
  input  wire logic level_in,
  // One-cycle pulse on a settled rising edge
  output logic      rise
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic settled_r;
  wire  agree = (s2_r == s3_r);

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s1_r      <= 1'b0;
      s2_r      <= 1'b0;
      s3_r      <= 1'b0;
      settled_r <= 1'b0;
    end else begin
      s1_r      <= level_in;
      s2_r      <= s1_r;
      s3_r      <= s2_r;
      settled_r <= agree ? s3_r : settled_r;
    end
  end

  assign rise = agree & s3_r & ~settled_r;

endmodule

// file: hw/irq_arbiter.sv
// Picks the winning request: level first, then lowest natural index
`timescale 1ns/1ps
module irq_arbiter #(
  parameter int N = 5
) (
  // Qualified requests and their levels
  input  wire logic [N-1:0]         pending,
  input  wire logic [N-1:0]         high,
  // Winner
  output logic                      found,
  output logic                      found_high,
  output logic [$clog2(N)-1:0]      index
);

  wire [N-1:0] hi_req = pending & high;
  wire [N-1:0] lo_req = pending & ~high;
  wire [N-1:0] pick   = (|hi_req) ? hi_req : lo_req;

  always_comb begin
    index = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (pick[i]) begin
        index = i[$clog2(N)-1:0];
      end
    end
  end

  assign found      = |pending;
  assign found_high = |hi_req;

endmodule

// file: hw/extended_interrupt_control.sv
// Extended interrupt unit: flags, enables, levels, arbitration, nesting
`timescale 1ns/1ps
`include "ext_irq_map.svh"

// What this block does
// R01 - Wakeup event sets wakeup flag
// R02 - Software clears wakeup flag, else refires
// R03 - Software writing wakeup flag requests interrupt
// R04 - Reserved bits read fixed values
// R05 - Wakeup enable gates wakeup interrupt
// R06 - Radio B enable gates its interrupt
// R07 - Radio A enable gates its interrupt
// R08 - Serial enable gates serial interrupt
// R09 - Conversion enable gates conversion interrupt
// R10 - Wakeup priority bit selects level
// R11 - Radio B priority bit selects level
// R12 - Radio A priority bit selects level
// R13 - Serial priority bit selects level
// R14 - Conversion priority bit selects level
// R15 - Taken interrupt jumps to fixed address
// R16 - Only higher level preempts running routine
// R17 - Return resumes at next instruction
// R18 - Conversion and serial events set flags
// R19 - Same level resolved by natural order
// R20 - Extra instruction after return or mask write; the code runs two more before service
// R21 - Radio edges set radio flags
// R22 - Request needs flag, enable, global enable
module extended_interrupt_control #(
  parameter int SOURCES = 5
) (
  // Clock and reset
  input  wire logic                      mclk,
  input  wire logic                      nrst,
  // Special-function register port
  input  wire ext_irq_pkg::sfr_req_type  sfr_req,
  output logic [7:0]                     sfr_rdata,
  output logic                           sfr_rvalid,
  // Peripheral event lines
  input  wire logic                      conversion_done,
  input  wire logic                      serial_byte_done,
  input  wire logic                      radio_data_ready_a,
  input  wire logic                      radio_data_ready_b,
  input  wire logic                      wakeup_timer_event,
  // CPU core
  input  wire logic                      global_irq_enable,
  input  wire logic                      instr_end,
  input  wire logic                      return_from_interrupt,
  input  wire logic                      std_mask_write,
  input  wire logic [15:0]               next_pc,
  output ext_irq_pkg::take_info_type     take_info,
  output logic                           resume_valid,
  output logic [15:0]                    resume_addr,
  output logic [1:0]                     in_service
);
  import ext_irq_pkg::*;

  // --------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------
  // Bit order of all three: conversion, serial, radio a, radio b, wakeup
  logic [SOURCES-1:0] flag_r;
  logic [SOURCES-1:0] flag_nxt;
  logic [SOURCES-1:0] enable_r;
  logic [SOURCES-1:0] enable_nxt;
  logic [SOURCES-1:0] priority_r;
  logic [SOURCES-1:0] priority_nxt;
  logic [7:0]         rdata_r;
  logic [7:0]         rdata_nxt;
  logic               rvalid_r;

  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------
  wire hit_flag    = (sfr_req.addr == `FLAG_REG_ADDR);
  wire hit_control = (sfr_req.addr == `CONTROL_REG_ADDR);
  wire hit_enable  = (sfr_req.addr == `ENABLE_REG_ADDR);
  wire hit_prio    = (sfr_req.addr == `PRIORITY_REG_ADDR);

  wire wr_flag     = sfr_req.wr & hit_flag;
  wire wr_control  = sfr_req.wr & hit_control;
  wire wr_enable   = sfr_req.wr & hit_enable;
  wire wr_prio     = sfr_req.wr & hit_prio;

  // --------------------------------------------------------------------
  // Event capture
  // --------------------------------------------------------------------
  logic [SOURCES-1:0] event_rise;
  wire  [SOURCES-1:0] event_line = {wakeup_timer_event,
                                    radio_data_ready_b,
                                    radio_data_ready_a,
                                    serial_byte_done,
                                    conversion_done};

  for (genvar g = 0; g < SOURCES; g++) begin : g_edge
    edge_catcher u_edge (
      .mclk     (mclk),
      .nrst     (nrst),
      .level_in (event_line[g]),
      .rise     (event_rise[g])
    );
  end

  // --------------------------------------------------------------------
  // Flags
  // --------------------------------------------------------------------
  // Software value per flag, kept when that register is not written
  wire [3:0] sw_ext_flags = wr_flag ? sfr_req.wdata[7:4] : flag_r[3:0];
  wire       sw_wake_flag = wr_control ? sfr_req.wdata[`WAKE_FLAG_BIT]
                                       : flag_r[src_wakeup];
  wire [SOURCES-1:0] sw_flags = {sw_wake_flag, sw_ext_flags};

  // A same-cycle event beats a software clear; a written 1 also requests
  assign flag_nxt = sw_flags | event_rise; // R01 R02 R03 R18 R21

  // --------------------------------------------------------------------
  // Enable and priority selects
  // --------------------------------------------------------------------
  assign enable_nxt   = wr_enable ? sfr_req.wdata[SOURCES-1:0]
                                  : enable_r;
  assign priority_nxt = wr_prio ? sfr_req.wdata[SOURCES-1:0]
                                : priority_r;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      flag_r     <= `FLAGS_RESET;
      enable_r   <= `SELECT_RESET;
      priority_r <= `SELECT_RESET;
    end else begin
      flag_r     <= flag_nxt;
      enable_r   <= enable_nxt;
      priority_r <= priority_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------
  wire [7:0] flag_view    = {flag_r[3:0], 4'h0} | `FLAG_FIXED_BITS; // R04
  wire [7:0] control_view = {4'h0, flag_r[src_wakeup], 3'h0}
                            | `CONTROL_FIXED_BITS; // R04
  wire [7:0] enable_view  = {3'h0, enable_r} | `SELECT_FIXED_BITS; // R04
  wire [7:0] prio_view    = {3'h0, priority_r} | `SELECT_FIXED_BITS; // R04

  // Unmapped addresses read zero; other units share this bus
  assign rdata_nxt = hit_flag    ? flag_view    :
                     hit_control ? control_view :
                     hit_enable  ? enable_view  :
                     hit_prio    ? prio_view    : 8'h00;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= sfr_req.rd ? rdata_nxt : rdata_r;
      rvalid_r <= sfr_req.rd;
    end
  end

  assign sfr_rdata  = rdata_r;
  assign sfr_rvalid = rvalid_r;

  // --------------------------------------------------------------------
  // Request qualification and arbitration
  // --------------------------------------------------------------------
  // Flag alone never interrupts; both enables must agree
  wire [SOURCES-1:0] pending = flag_r & enable_r
                               & {SOURCES{global_irq_enable}};
  // R05 R06 R07 R08 R09 R22

  logic                       best_found;
  logic                       best_high;
  logic [$clog2(SOURCES)-1:0] best_index;

  irq_arbiter #(
    .N (SOURCES)
  ) u_arb (
    .pending    (pending),
    .high       (priority_r), // R10 R11 R12 R13 R14
    .found      (best_found),
    .found_high (best_high),
    .index      (best_index)
  ); // R19

  logic [15:0] best_vector;

  always_comb begin
    case (best_index)
      3'd0: best_vector = `VEC_CONVERSION; // R15
      3'd1: best_vector = `VEC_SERIAL;
      3'd2: best_vector = `VEC_RADIO_A;
      3'd3: best_vector = `VEC_RADIO_B;
      3'd4: best_vector = `VEC_WAKEUP;
      default: best_vector = `VEC_CONVERSION;
    endcase
  end

  // --------------------------------------------------------------------
  // Nesting: one slot per level
  // --------------------------------------------------------------------
  logic        hi_active_r;
  logic        lo_active_r;
  logic [15:0] hi_return_r;
  logic [15:0] lo_return_r;

  // High preempts low only; nothing preempts high
  wire level_free = best_high ? ~hi_active_r
                              : (~hi_active_r & ~lo_active_r); // R16

  // --------------------------------------------------------------------
  // Instruction-boundary gate
  // --------------------------------------------------------------------
  gate_state_type gate_r;
  gate_state_type gate_nxt;
  logic           touched_r;

  // Something in the current instruction delays service by two more instructions
  wire touched_now = touched_r | return_from_interrupt | std_mask_write
                     | wr_enable | wr_prio;

  always_comb begin
    case (gate_r)
      gate_open: gate_nxt = (instr_end & touched_now) ? gate_hold
                                                      : gate_open;
      gate_hold: gate_nxt = instr_end ? gate_open : gate_hold;
      default:   gate_nxt = gate_open;
    endcase
  end

  // Service only at a clean boundary after the instruction completes
  wire boundary_ok = instr_end & (gate_r == gate_open)
                     & ~touched_now; // R20
  wire take_now    = boundary_ok & best_found & level_free;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      gate_r    <= gate_open;
      touched_r <= 1'b0;
    end else begin
      gate_r    <= gate_nxt;
      touched_r <= instr_end ? 1'b0 : touched_now;
    end
  end

  // --------------------------------------------------------------------
  // Take and return
  // --------------------------------------------------------------------
  // Return closes the innermost routine, which is high when both run
  wire ret_hi = return_from_interrupt & hi_active_r;
  wire ret_lo = return_from_interrupt & ~hi_active_r & lo_active_r;

  wire take_hi = take_now & best_high;
  wire take_lo = take_now & ~best_high;

  take_info_type take_r;
  logic          resume_valid_r;
  logic [15:0]   resume_addr_r;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      hi_active_r <= 1'b0;
      lo_active_r <= 1'b0;
      hi_return_r <= `PC_RESET;
      lo_return_r <= `PC_RESET;
    end else begin
      hi_active_r <= take_hi | (hi_active_r & ~ret_hi);
      lo_active_r <= take_lo | (lo_active_r & ~ret_lo);
      hi_return_r <= take_hi ? next_pc : hi_return_r; // R17
      lo_return_r <= take_lo ? next_pc : lo_return_r; // R17
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      take_r         <= '0;
      resume_valid_r <= 1'b0;
      resume_addr_r  <= `PC_RESET;
    end else begin
      take_r.take    <= take_now; // R15
      take_r.high    <= take_now ? best_high : take_r.high;
      take_r.vector  <= take_now ? best_vector : take_r.vector;
      resume_valid_r <= ret_hi | ret_lo;
      resume_addr_r  <= ret_hi ? hi_return_r :
                        ret_lo ? lo_return_r : resume_addr_r; // R17
    end
  end

  assign take_info    = take_r;
  assign resume_valid = resume_valid_r;
  assign resume_addr  = resume_addr_r;
  assign in_service   = {hi_active_r, lo_active_r};

endmodule

// file: tb/ext_irq_sva.sv
// Port-level assertions of the extended interrupt unit
`timescale 1ns/1ps
module ext_irq_sva (
  // Clock and reset
  input wire logic                     mclk,
  input wire logic                     nrst,
  // Register port
  input wire ext_irq_pkg::sfr_req_type sfr_req,
  input wire logic [7:0]               sfr_rdata,
  input wire logic                     sfr_rvalid,
  // CPU side
  input wire logic                     global_irq_enable,
  input wire logic                     instr_end,
  input wire logic                     return_from_interrupt,
  input wire ext_irq_pkg::take_info_type take_info,
  input wire logic                     resume_valid,
  input wire logic [1:0]               in_service
);
  // ----------------------------------------------------------------
  // Register answers and interrupt entry and exit
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  rd_answer_a: assert property (sfr_req.rd |=> sfr_rvalid)
    else $error("read not answered");
  rvalid_cause_a: assert property (sfr_rvalid |-> $past(sfr_req.rd))
    else $error("read answer without read");
  flag_fixed_a: assert property (sfr_req.rd && sfr_req.addr == 8'h91
    |=> sfr_rdata[3:0] == 4'h8) else $error("flag reserved bits wrong");
  ctrl_fixed_a: assert property (sfr_req.rd && sfr_req.addr == 8'hd8
    |=> sfr_rdata[7:4] == 4'h4 && sfr_rdata[2:0] == 3'h0)
    else $error("control reserved bits wrong");
  mask_fixed_a: assert property (sfr_req.rd
    && (sfr_req.addr == 8'he8 || sfr_req.addr == 8'hf8)
    |=> sfr_rdata[7:5] == 3'h7)
    else $error("enable or level reserved bits wrong");
  unmapped_read_a: assert property (sfr_req.rd && sfr_req.addr == 8'h00
    |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
  take_gate_a: assert property (take_info.take
    |-> $past(instr_end) && $past(global_irq_enable))
    else $error("take outside instruction end or while masked");
  take_vector_a: assert property (take_info.take |-> take_info.vector
    inside {16'h0043, 16'h004b, 16'h0053, 16'h005b, 16'h0063})
    else $error("vector not a service address");
  take_level_a: assert property (take_info.take
    |-> (take_info.high ? in_service[1] : in_service[0]))
    else $error("level not marked active");
  low_preempt_a: assert property (take_info.take && !take_info.high
    |-> $past(in_service) == 2'b00) else $error("low entry over active");
  resume_cause_a: assert property (resume_valid
    |-> $past(return_from_interrupt)) else $error("resume without return");
endmodule

// file: tb/cpu_model.sv
// Behavioural CPU core: instruction ends and next-address counter
`timescale 1ns/1ps
module cpu_model #(
  parameter int PERIOD = 4
) (
  // Clock and reset
  input  wire logic   mclk,
  input  wire logic   nrst,
  // Instruction stream
  output logic        instr_end,
  output logic [15:0] next_pc
);
  int cnt;

  // Falling edge keeps the unit's sampling edge race free
  always @(negedge mclk) begin
    if (!nrst) begin
      cnt <= 0;
      instr_end <= 1'b0;
      next_pc <= 16'h0100;
    end else begin
      if (instr_end)
        next_pc <= next_pc + 16'h0001;
      instr_end <= (cnt == PERIOD - 1);
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
    end
  end
endmodule

// file: tb/tb_extended_interrupt_control.sv
// Self-checking bench of the extended interrupt unit
`timescale 1ns/1ps
`include "ext_irq_map.svh"
module tb_extended_interrupt_control;
  import ext_irq_pkg::*;
  logic          mclk, nrst, gie, ret, mwr, rvalid, iend, rvld;
  logic [4:0]    ev;
  sfr_req_type   req;
  logic [7:0]    rdata;
  logic [15:0]   npc, raddr;
  take_info_type ti;
  logic [1:0]    ins;
  logic [15:0]   vec_tab [5];
  logic [15:0]   saved_pc [2];
  int            num_errors, n_checks, n_end;

  extended_interrupt_control dut (.mclk(mclk), .nrst(nrst),
    .sfr_req(req), .sfr_rdata(rdata), .sfr_rvalid(rvalid),
    .conversion_done(ev[0]), .serial_byte_done(ev[1]),
    .radio_data_ready_a(ev[2]), .radio_data_ready_b(ev[3]),
    .wakeup_timer_event(ev[4]), .global_irq_enable(gie),
    .instr_end(iend), .return_from_interrupt(ret), .std_mask_write(mwr),
    .next_pc(npc), .take_info(ti), .resume_valid(rvld),
    .resume_addr(raddr), .in_service(ins));
  cpu_model #(.PERIOD(4)) cpu (.mclk(mclk), .nrst(nrst),
    .instr_end(iend), .next_pc(npc));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    req = '{a, 1'b1, 1'b0, d};
    @(negedge mclk);
    req.wr = 1'b0;
  endtask

  task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk);
    req = '{a, 1'b0, 1'b1, 8'h00};
    @(negedge mclk);
    req.rd = 1'b0;
    check(rvalid, 1'b1);
    check(rdata, exp);
  endtask

  task automatic pulse(input int i);
    @(negedge mclk);
    ev[i] = 1'b1;
    repeat (6) @(negedge mclk);
    ev[i] = 1'b0;
    repeat (6) @(negedge mclk);
  endtask

  task automatic wait_take(input logic [15:0] v, input logic h);
    int k = 0;
    do begin
      @(posedge mclk);
      #1;
      k++;
    end while (ti.take !== 1'b1 && k < 100);
    check(ti.take, 1'b1);
    check(ti.vector, v);
    check(ti.high, h);
    saved_pc[h] = npc;
  endtask

  task automatic leave(input logic h, input logic [1:0] rest);
    @(negedge mclk);
    ret = 1'b1;
    @(negedge mclk);
    ret = 1'b0;
    check(rvld, 1'b1);
    check(raddr, saved_pc[h]);
    check(ins, rest);
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Whole run needs a few hundred cycles
  initial begin
    #200000;
    num_errors++;
    report_and_stop();
  end

  initial begin
    nrst = 1'b0;
    gie = 1'b0;
    ret = 1'b0;
    mwr = 1'b0;
    ev = 5'h00;
    req = '0;
    num_errors = 0;
    n_checks = 0;
    vec_tab = '{`VEC_CONVERSION, `VEC_SERIAL, `VEC_RADIO_A, `VEC_RADIO_B,
                `VEC_WAKEUP};
    repeat (10) @(negedge mclk);
    nrst = 1'b1;
    // ----------------------------------------------------------------
    // Fixed bits, unmapped place, event flags
    // ----------------------------------------------------------------
    sfr_rd(`FLAG_REG_ADDR, 8'h08);
    sfr_rd(`CONTROL_REG_ADDR, 8'h40);
    sfr_rd(`ENABLE_REG_ADDR, 8'he0);
    sfr_wr(`PRIORITY_REG_ADDR, 8'h1f);
    sfr_rd(`PRIORITY_REG_ADDR, 8'hff);
    sfr_wr(8'h00, 8'hff);
    sfr_rd(8'h00, 8'h00);
    for (int i = 0; i < 4; i++) begin
      pulse(i);
      sfr_rd(`FLAG_REG_ADDR, 8'h08 | 8'(8'h10 << i));
      sfr_wr(`FLAG_REG_ADDR, 8'h00);
    end
    pulse(4);
    sfr_rd(`CONTROL_REG_ADDR, 8'h48);
    sfr_wr(`CONTROL_REG_ADDR, 8'h00);
    // ----------------------------------------------------------------
    // Masking, natural order, preemption, return
    // ----------------------------------------------------------------
    sfr_wr(`PRIORITY_REG_ADDR, 8'h00);
    sfr_wr(`ENABLE_REG_ADDR, 8'h1f);
    sfr_wr(`FLAG_REG_ADDR, 8'hf0);
    sfr_wr(`CONTROL_REG_ADDR, 8'h08);
    repeat (40) @(negedge mclk);
    check(ins, 2'b00);
    gie = 1'b1;
    wait_take(`VEC_CONVERSION, 1'b0);
    sfr_wr(`PRIORITY_REG_ADDR, 8'h10);
    wait_take(`VEC_WAKEUP, 1'b1);
    check(ins, 2'b11);
    sfr_wr(`FLAG_REG_ADDR, 8'h00);
    sfr_wr(`CONTROL_REG_ADDR, 8'h00);
    leave(1'b1, 2'b01);
    leave(1'b0, 2'b00);
    // One source enabled at a time, others pending but masked
    for (int i = 0; i < 5; i++) begin
      // Narrow the enables first so no stale source can slip in
      sfr_wr(`PRIORITY_REG_ADDR, i % 2 ? 8'h00 : 8'(1 << i));
      sfr_wr(`ENABLE_REG_ADDR, 8'(1 << i));
      sfr_wr(`FLAG_REG_ADDR, 8'hf0);
      sfr_wr(`CONTROL_REG_ADDR, 8'h08);
      wait_take(vec_tab[i], !(i % 2));
      sfr_wr(`FLAG_REG_ADDR, 8'h00);
      sfr_wr(`CONTROL_REG_ADDR, 8'h00);
      leave(!(i % 2), 2'b00);
    end
    // Software-set wakeup flag, left set, fires again
    sfr_wr(`CONTROL_REG_ADDR, 8'h08);
    wait_take(`VEC_WAKEUP, 1'b1);
    leave(1'b1, 2'b00);
    wait_take(`VEC_WAKEUP, 1'b1);
    sfr_wr(`CONTROL_REG_ADDR, 8'h00);
    leave(1'b1, 2'b00);
    // Standard mask write holds service back two more instructions
    gie = 1'b0;
    sfr_wr(`FLAG_REG_ADDR, 8'h10);
    sfr_wr(`ENABLE_REG_ADDR, 8'h01);
    repeat (12) @(negedge mclk);
    gie = 1'b1;
    mwr = 1'b1;
    @(posedge mclk);
    n_end = int'(iend);
    @(negedge mclk);
    mwr = 1'b0;
    do begin
      @(posedge mclk);
      #1;
      n_end += int'(iend);
    end while (ti.take !== 1'b1 && n_end < 8);
    check(16'(n_end), 16'h0003);
    check(ti.vector, `VEC_CONVERSION);
    saved_pc[0] = npc;
    sfr_wr(`FLAG_REG_ADDR, 8'h00);
    leave(1'b0, 2'b00);
    report_and_stop();
  end
endmodule

bind extended_interrupt_control ext_irq_sva chk (.mclk(mclk), .nrst(nrst),
  .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid),
  .global_irq_enable(global_irq_enable), .instr_end(instr_end),
  .return_from_interrupt(return_from_interrupt), .take_info(take_info),
  .resume_valid(resume_valid), .in_service(in_service));
